// file: cbr_pkg.sv
// Package for the clock buffer management register bank.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package cbr_pkg;

	// ==========================================================
	// Register indices
	localparam logic [7:0] IDX_OE_LOW    = 8'h01;
	localparam logic [7:0] IDX_OE_HIGH   = 8'h02;
	localparam logic [7:0] IDX_RSVD3     = 8'h03;
	localparam logic [7:0] IDX_RSVD4     = 8'h04;
	localparam logic [7:0] IDX_REV_MAKER = 8'h05;
	localparam logic [7:0] IDX_PART      = 8'h06;
	localparam logic [7:0] IDX_COUNT     = 8'h07;

	// ==========================================================
	// Reset values and device address
	localparam logic [7:0]  OE_LOW_RESET  = 8'hff;
	localparam logic [3:0]  OE_HIGH_RESET = 4'hf;
	localparam logic [4:0]  COUNT_RESET   = 5'h08;
	localparam logic [6:0]  DEV_ADDR      = 7'h6c;

	// Identity values, arbitrary
	localparam logic [3:0]  REVISION_CODE = 4'h3;
	localparam logic [3:0]  MAKER_CODE    = 4'h5;
	localparam logic [7:0]  PART_CODE     = 8'h5a;

	// ==========================================================
	// Serial protocol states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_ACK   = 3'b010,
		ST_RX    = 3'b011,
		ST_TX    = 3'b100,
		ST_RACK  = 3'b101,
		ST_SKIP  = 3'b110
	} cbr_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} cbr_bus_t;

endpackage

// file: cbr_edge.sv
// Line conditioner: compares the serial lines with their values one cycle earlier, flags edges and conditions, and passes SDA through undelayed.
// Assumes lines are already synchronous to clock_i.
`timescale 1ns/1ps
module cbr_edge (
	input  wire logic            clock_i,
	input  wire logic            rst_i,
	input  wire cbr_pkg::cbr_bus_t line_i,
	output logic                 scl_rise_o,
	output logic                 scl_fall_o,
	output logic                 start_o,
	output logic                 stop_o,
	output logic                 sda_o
);
	cbr_pkg::cbr_bus_t prev;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			prev <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			prev <= line_i;
		end
	end

	assign scl_rise_o = line_i.scl & ~prev.scl;
	assign scl_fall_o = ~line_i.scl & prev.scl;
	assign start_o    = line_i.scl & prev.scl & prev.sda & ~line_i.sda;
	assign stop_o     = line_i.scl & prev.scl & ~prev.sda & line_i.sda;
	assign sda_o      = line_i.sda;
endmodule

// file: cbr_regs.sv
// Management register bank of a twelve-output differential clock buffer, on the two-wire bus.
// Assumes serial lines synchronous to clock_i and open-drain SDA resolved outside.
//
// Overview of operation
// - Enable bits 7..4 of byte 1 gate outputs 7..4 and override the matching hardware enable pins.
// - Each output enable bit is read/write, resets to one, and zero forces its pair to low/low.
// - Byte 5 returns revision and maker codes and byte 6 returns the part code, both read-only.
// - Byte 7 bits 4..0 hold the count of bytes that block reads return, bits 7..5 read zero.
// - A block read returns the count then successive bytes from an auto-incremented index.
`timescale 1ns/1ps
module cbr_regs (
	input  wire logic         clock_i,
	input  wire logic         rst_i,
	input  wire logic         scl_i,
	input  wire logic         sda_i,
	input  wire logic [3:0]   oe_pin_n_i,
	output logic              sda_o,
	output logic              sda_oe_o,
	output logic [11:0]       out_run_o
);
	logic                scl_rise;
	logic                scl_fall;
	logic                start_c;
	logic                stop_c;
	logic                sda_s;
	cbr_pkg::cbr_state_t state;
	logic [7:0]          shreg;
	logic [3:0]          bitcnt;
	logic                rw_read;
	logic [1:0]          phase;
	logic [7:0]          index;
	logic [4:0]          remain;
	logic [7:0]          oe_low;
	logic [3:0]          oe_high;
	logic [4:0]          count;
	logic [7:0]          rd_data;
	logic                addr_ok;
	logic                first_tx;
	cbr_pkg::cbr_bus_t   bus_line;

	assign bus_line = '{scl: scl_i, sda: sda_i};

	cbr_edge u_edge (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.line_i     (bus_line),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o    (start_c),
		.stop_o     (stop_c),
		.sda_o      (sda_s)
	);

	// ==========================================================
	// Read multiplexer
	always_comb begin
		if (index == cbr_pkg::IDX_OE_LOW) begin
			rd_data = oe_low;
		end else if (index == cbr_pkg::IDX_OE_HIGH) begin
			rd_data = {4'h0, oe_high};
		end else if (index == cbr_pkg::IDX_REV_MAKER) begin
			rd_data = {cbr_pkg::REVISION_CODE, cbr_pkg::MAKER_CODE};
		end else if (index == cbr_pkg::IDX_PART) begin
			rd_data = cbr_pkg::PART_CODE;
		end else if (index == cbr_pkg::IDX_COUNT) begin
			rd_data = {3'h0, count};
		end else begin
			rd_data = 8'h00;
		end
	end

	assign addr_ok = (shreg[7:1] == cbr_pkg::DEV_ADDR);

	// ==========================================================
	// Serial protocol engine
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state    <= cbr_pkg::ST_IDLE;
			shreg    <= 8'h00;
			bitcnt   <= 4'h0;
			rw_read  <= 1'b0;
			phase    <= 2'd0;
			index    <= 8'h00;
			remain   <= 5'h00;
			sda_o    <= 1'b0;
			sda_oe_o <= 1'b0;
			first_tx <= 1'b0;
		end else if (stop_c) begin
			state    <= cbr_pkg::ST_IDLE;
			sda_oe_o <= 1'b0;
		end else if (start_c) begin
			state    <= cbr_pkg::ST_ADDR;
			bitcnt   <= 4'h0;
			phase    <= 2'd0;
			sda_oe_o <= 1'b0;
		end else begin
			case (state)
				cbr_pkg::ST_ADDR, cbr_pkg::ST_RX: begin
					if (scl_rise) begin
						shreg  <= {shreg[6:0], sda_s};
						bitcnt <= bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == 4'h8) begin
						bitcnt <= 4'h0;
						if (state == cbr_pkg::ST_ADDR) begin
							if (addr_ok) begin
								rw_read  <= shreg[0];
								sda_oe_o <= 1'b1;
								state    <= cbr_pkg::ST_ACK;
								first_tx <= shreg[0];
							end else begin
								state <= cbr_pkg::ST_SKIP;
							end
						end else begin
							sda_oe_o <= 1'b1;
							state    <= cbr_pkg::ST_ACK;
							if (phase == 2'd0) begin
								index <= shreg;
								phase <= 2'd1;
							end else if (phase == 2'd1) begin
								remain <= shreg[4:0];
								phase  <= 2'd2;
							end else if (remain != 5'h00) begin
								index  <= index + 8'h01;
								remain <= remain - 5'h01;
							end
						end
					end
				end
				cbr_pkg::ST_ACK: begin
					if (scl_fall) begin
						if (rw_read) begin
							// Count byte starts with a reserved zero, so its first bit is always driven low
							sda_oe_o <= first_tx ? 1'b1 : ~rd_data[7];
							shreg    <= first_tx ? {3'h0, count} : rd_data;
							if (!first_tx) begin
								index <= index + 8'h01;
							end
							first_tx <= 1'b0;
							state    <= cbr_pkg::ST_TX;
						end else begin
							sda_oe_o <= 1'b0;
							state    <= cbr_pkg::ST_RX;
						end
					end
				end
				cbr_pkg::ST_TX: begin
					if (scl_fall) begin
						if (bitcnt == 4'h7) begin
							bitcnt   <= 4'h0;
							sda_oe_o <= 1'b0;
							state    <= cbr_pkg::ST_RACK;
						end else begin
							bitcnt   <= bitcnt + 4'h1;
							shreg    <= {shreg[6:0], 1'b0};
							sda_oe_o <= ~shreg[6];
						end
					end
				end
				cbr_pkg::ST_RACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							state <= cbr_pkg::ST_SKIP;
						end else begin
							state <= cbr_pkg::ST_ACK;
						end
					end
				end
				default: begin
					sda_oe_o <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Register writes
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			oe_low  <= cbr_pkg::OE_LOW_RESET;
			oe_high <= cbr_pkg::OE_HIGH_RESET;
			count   <= cbr_pkg::COUNT_RESET;
		end else if (state == cbr_pkg::ST_RX && scl_fall && bitcnt == 4'h8
			     && phase == 2'd2 && remain != 5'h00) begin
			if (index == cbr_pkg::IDX_OE_LOW) begin
				oe_low <= shreg;
			end else if (index == cbr_pkg::IDX_OE_HIGH) begin
				oe_high <= shreg[3:0];
			end else if (index == cbr_pkg::IDX_COUNT) begin
				count <= shreg[4:0];
			end
		end
	end

	// ==========================================================
	// Output gating
	// Outputs 4..7 follow the register alone; their hardware enable pins carry no weight
	genvar g;
	generate
		for (g = 0; g < 12; g++) begin : g_out
			if (g >= 4 && g < 8) begin : g_pin
				always_ff @(posedge clock_i) begin
					if (rst_i) begin
						out_run_o[g] <= 1'b0;
					end else begin
						out_run_o[g] <= oe_low[g];
					end
				end
			end else if (g < 4) begin : g_low
				always_ff @(posedge clock_i) begin
					if (rst_i) begin
						out_run_o[g] <= 1'b0;
					end else begin
						out_run_o[g] <= oe_low[g];
					end
				end
			end else begin : g_high
				always_ff @(posedge clock_i) begin
					if (rst_i) begin
						out_run_o[g] <= 1'b0;
					end else begin
						out_run_o[g] <= oe_high[g - 8];
					end
				end
			end
		end
	endgenerate
endmodule

// file: cbr_host.sv
// Bus host model driving clock and data for indexed block transfers.
// Assumes SDA is resolved with a pull-up outside this model.
`timescale 1ns/1ps
module cbr_host (
	input  wire logic clock_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_pull_o
);
	// ==========
	// Bus phases
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	task automatic wt();
		repeat (4) @(posedge clock_i);
	endtask
	task automatic bt(input logic b, output logic r);
		sda_pull_o <= ~b;
		wt();
		scl_o <= 1'b1;
		wt();
		r = sda_i;
		scl_o <= 1'b0;
		wt();
	endtask
	// Also serves as repeated start
	task automatic start();
		sda_pull_o <= 1'b0;
		wt();
		scl_o <= 1'b1;
		wt();
		sda_pull_o <= 1'b1;
		wt();
		scl_o <= 1'b0;
		wt();
	endtask
	task automatic stop();
		sda_pull_o <= 1'b1;
		wt();
		scl_o <= 1'b1;
		wt();
		sda_pull_o <= 1'b0;
		wt();
	endtask
	// Ak is the level sent in the ninth slot
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bt(d[i], q[i]);
		bt(ak, a);
	endtask
endmodule

// file: cbr_regs_assertions.sv
// Checker on the register bank ports.
// Assumes one clock domain and synchronous reset.
`timescale 1ns/1ps
module cbr_regs_chk (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        scl_i,
	input wire logic        sda_i,
	input wire logic [3:0]  oe_pin_n_i,
	input wire logic        sda_o,
	input wire logic        sda_oe_o,
	input wire logic [11:0] out_run_o
);
	// ==========
	// Port rules
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence s_stop;
		scl_i && !sda_i ##1 scl_i && sda_i;
	endsequence
	chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> out_run_o == 12'h000 && !sda_oe_o)
		else $error("outputs active in reset");
	chk_release_run: assert property ($fell(rst_i) |=> out_run_o == 12'hfff)
		else $error("outputs not running after reset");
	chk_pins_ignored: assert property ($changed(oe_pin_n_i) |=> $stable(out_run_o))
		else $error("enable pins moved outputs");
	chk_drive_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data changed with clock high");
	chk_open_drain: assert property (sda_o == 1'b0)
		else $error("data drive value not low");
	chk_stop_release: assert property (s_stop |=> !sda_oe_o)
		else $error("data held after stop");
endmodule
bind cbr_regs cbr_regs_chk u_chk (.clock_i, .rst_i, .scl_i, .sda_i, .oe_pin_n_i, .sda_o, .sda_oe_o, .out_run_o);

// file: test_smbus_output_enable_and_id_registers.sv
// Self-checking bench for the register bank.
// Assumes cbr_host drives the bus and SDA has a pull-up.
`timescale 1ns/1ps
module test_smbus_output_enable_and_id_registers;
	logic       clock_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [3:0] oe_pin_n_i = 4'h0;
	logic       scl, sda_pull, sda_o, sda_oe_o;
	logic [11:0] out_run_o;
	wire        sda = ~(sda_pull | sda_oe_o);
	int         n_errors = 0;
	int         tests_run = 0;
	logic [7:0] q [4];
	logic [7:0] cnt;
	localparam logic [7:0] AW = {cbr_pkg::DEV_ADDR, 1'b0};
	always #5 clock_i = ~clock_i;
	cbr_regs u_dut (.clock_i, .rst_i, .scl_i(scl), .sda_i(sda), .oe_pin_n_i, .sda_o, .sda_oe_o, .out_run_o);
	cbr_host u_host (.clock_i, .sda_i(sda), .scl_o(scl), .sda_pull_o(sda_pull));
	// ==========
	// Tasks
	task automatic check(input string w, input logic [11:0] s, input logic [11:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", w, e, s);
		end
	endtask
	task automatic send(input logic [7:0] d, input logic nak = 1'b0);
		logic [7:0] r;
		logic a;
		u_host.xfer(d, 1'b1, r, a);
		check("ack", a, nak);
	endtask
	task automatic wr(input logic [7:0] idx, input int n, input logic [15:0] d);
		u_host.start();
		send(AW);
		send(idx);
		send(n[7:0]);
		for (int i = 0; i < n; i++)
			send(d[15-8*i -: 8]);
		u_host.stop();
	endtask
	task automatic rd(input logic [7:0] idx, input int n);
		logic a;
		u_host.start();
		send(AW);
		send(idx);
		u_host.start();
		send(AW | 8'h01);
		u_host.xfer(8'hff, 1'b0, cnt, a);
		for (int i = 0; i < n; i++)
			u_host.xfer(8'hff, i == n - 1, q[i], a);
		u_host.stop();
	endtask
	task automatic t_reset();
		check("run", out_run_o, 12'hfff);
		oe_pin_n_i <= 4'hf;
		repeat (3) @(posedge clock_i);
		check("pins", out_run_o, 12'hfff);
	endtask
	task automatic t_ids();
		wr(8'h03, 2, 16'hffff);
		wr(8'h05, 2, 16'h0000);
		rd(8'h03, 4);
		check("count", cnt, cbr_pkg::COUNT_RESET);
		check("rsvd3", q[0], 8'h00);
		check("rsvd4", q[1], 8'h00);
		check("rev", q[2], {cbr_pkg::REVISION_CODE, cbr_pkg::MAKER_CODE});
		check("part", q[3], cbr_pkg::PART_CODE);
	endtask
	task automatic t_enables();
		wr(8'h01, 2, 16'hf0fa);
		check("run", out_run_o, 12'haf0);
		rd(8'h01, 2);
		check("oe lo", q[0], 8'hf0);
		check("oe hi", q[1], 8'h0a);
	endtask
	task automatic t_count();
		wr(8'h07, 1, 16'hff00);
		rd(8'h07, 1);
		check("count", cnt, 8'h1f);
		check("count reg", q[0], 8'h1f);
		u_host.start();
		send(~AW, 1'b1);
		u_host.stop();
	endtask
	task automatic t_excess();
		u_host.start();
		send(AW);
		send(8'h01);
		send(8'h01);
		send(8'h0f);
		send(8'h00);
		u_host.stop();
		check("run", out_run_o, 12'ha0f);
		rd(8'h01, 2);
		check("oe lo", q[0], 8'h0f);
		check("oe hi", q[1], 8'h0a);
	endtask
	task automatic finish_test();
		$display("errors %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		t_reset();
		t_ids();
		t_enables();
		t_count();
		t_excess();
		finish_test();
	end
	initial begin
		repeat (50000) @(posedge clock_i);
		n_errors++;
		finish_test();
	end
endmodule
